// file: hdl/sidc_pkg.sv
// How it works
// - Six masked status bits read as sticky raw flag AND mask enable.
// - Receive overrun is raised by a receive FIFO write while full; mask one enables.
// - Writing one to clear bit 0 clears receive overrun.
// - Writing one to clear bit 1 clears receive timeout.
// - Writing one to clear bit 2 clears transmit underrun.
// - Receive DMA enable bit 0 gates single receive DMA requests.
// - Transmit DMA enable bit 2 gates single transmit DMA requests.
// - Sixteen-bit read-write receive frame count, reset zero.
// - Sixteen-bit frame count from transmit FIFO, reset zero.
// - Swap bit zero: test data write pushes transmit FIFO, read pops receive FIFO.
// - Swap bit one: test data write pushes receive FIFO, read pops transmit FIFO.
package sidc_pkg;
  localparam logic [7:0] ADDR_IMASK = 8'h14;
  localparam logic [7:0] ADDR_RAW = 8'h18;
  localparam logic [7:0] ADDR_MIS = 8'h1c;
  localparam logic [7:0] ADDR_ICLR = 8'h20;
  localparam logic [7:0] ADDR_DMAC = 8'h24;
  localparam logic [7:0] ADDR_RX_FRAME_COUNT = 8'h28;
  localparam logic [7:0] ADDR_DUMMY = 8'h2c;
  localparam logic [7:0] ADDR_TXFRM = 8'h30;
  localparam logic [7:0] ADDR_TCTL = 8'h80;
  localparam logic [7:0] ADDR_TDATA = 8'h8c;
  localparam int IRQ_ROR = 0;
  localparam int IRQ_RT = 1;
  localparam int IRQ_RX = 2;
  localparam int IRQ_TX = 3;
  localparam int IRQ_TUR = 4;
  localparam int IRQ_TE = 5;
  localparam int NIRQ = 6;
  localparam int DMA_RX_BIT = 0;
  localparam int DMA_TX_BIT = 2;
  localparam int SWAP_BIT = 1;
  localparam logic [5:0] IRQ_RESET = 6'h00;
  localparam logic [15:0] FRM_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef struct packed {
    logic rxTimeout;
    logic rxLevel;
    logic txLevel;
    logic txUnderrun;
    logic txEmpty;
  } sidc_events_t;
  typedef struct packed {
    logic txReq;
    logic rxReq;
  } sidc_dma_t;
endpackage

// file: hdl/sidc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sidc_ctrl #(
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire sidc_pkg::sidc_events_t events,
  input wire logic rxFull,
  input wire logic rxWrite,
  input wire logic rxDmaNeed,
  input wire logic txDmaNeed,
  output sidc_pkg::sidc_dma_t dmaReq,
  input wire logic rxOnly,
  input wire logic [4:0] frameBits,
  output logic [31:0] txDummyData,
  output logic [15:0] rxFrameCount,
  output logic [15:0] txfifoRxFrameCount,
  output logic fifoSwapSelect,
  output logic txPush,
  output logic rxPush,
  output logic [DW-1:0] testPushData,
  output logic txPop,
  output logic rxPop,
  input wire logic [DW-1:0] txHead,
  input wire logic [DW-1:0] rxHead,
  output logic irq
);
  import sidc_pkg::*;

  logic [5:0] rawIrq_r;
  logic [5:0] mask_r;
  logic [2:0] dmaCtl_r;
  logic [15:0] rx_frame_count_r;
  logic [15:0] txFrm_r;
  logic [31:0] dummy_r;
  logic [1:0] testCtl_r;
  logic wrPend_r;
  logic rdPend_r;
  logic [7:0] addr_r;
  logic [31:0] rdData_r;
  logic [5:0] maskedIrq;
  logic [5:0] setIrq;
  logic [5:0] clrIrq;
  logic [31:0] rdMux;
  logic addrTake;
  logic [31:0] dummyMask;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_r;
  assign addrTake = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wrPend_r <= addrTake && hwrite;
      rdPend_r <= addrTake && !hwrite;
      if (addrTake) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // Reads are decoded in the address phase so that data stands at the data phase edge.
  always_comb begin
    rdMux = 32'h00000000;
    unique case (haddr[7:0])
      ADDR_IMASK: rdMux = {26'h0000000, mask_r};
      ADDR_RAW: rdMux = {26'h0000000, rawIrq_r};
      ADDR_MIS: rdMux = {26'h0000000, maskedIrq};
      ADDR_DMAC: rdMux = {29'h00000000, dmaCtl_r};
      ADDR_RX_FRAME_COUNT: rdMux = {16'h0000, rx_frame_count_r};
      ADDR_DUMMY: rdMux = dummy_r;
      ADDR_TXFRM: rdMux = {16'h0000, txFrm_r};
      ADDR_TCTL: rdMux = {30'h00000000, testCtl_r};
      ADDR_TDATA: rdMux = 32'(testCtl_r[SWAP_BIT] ? txHead : rxHead);
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_r <= WORD_RESET;
    end else if (addrTake && !hwrite) begin
      rdData_r <= rdMux;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_r <= IRQ_RESET;
      dmaCtl_r <= 3'h0;
      rx_frame_count_r <= FRM_RESET;
      txFrm_r <= FRM_RESET;
      dummy_r <= WORD_RESET;
      testCtl_r <= 2'h0;
    end else if (wrPend_r) begin
      unique case (addr_r)
        ADDR_IMASK: mask_r <= hwdata[5:0];
        ADDR_DMAC: dmaCtl_r <= hwdata[2:0];
        ADDR_RX_FRAME_COUNT: rx_frame_count_r <= hwdata[15:0];
        ADDR_DUMMY: dummy_r <= hwdata;
        ADDR_TXFRM: txFrm_r <= hwdata[15:0];
        ADDR_TCTL: testCtl_r <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Overrun is detected here from the FIFO write and full lines; the rest arrive raw.
  always_comb begin
    setIrq = 6'h00;
    setIrq[IRQ_ROR] = (rxWrite || rxPush) && rxFull;
    setIrq[IRQ_RT] = events.rxTimeout;
    setIrq[IRQ_RX] = events.rxLevel;
    setIrq[IRQ_TX] = events.txLevel;
    setIrq[IRQ_TUR] = events.txUnderrun;
    setIrq[IRQ_TE] = events.txEmpty;
    clrIrq = 6'h00;
    if (wrPend_r && addr_r == ADDR_ICLR) begin
      clrIrq[IRQ_ROR] = hwdata[0];
      clrIrq[IRQ_RT] = hwdata[1];
      clrIrq[IRQ_TUR] = hwdata[2];
    end
    // A read of the masked status clears the level flags; write-one clears the error flags.
    if (rdPend_r && addr_r == ADDR_MIS) begin
      clrIrq[IRQ_RX] = 1'b1;
      clrIrq[IRQ_TX] = 1'b1;
      clrIrq[IRQ_TE] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rawIrq_r <= IRQ_RESET;
    end else begin
      rawIrq_r <= setIrq | (rawIrq_r & ~clrIrq);
    end
  end

  assign maskedIrq = rawIrq_r & mask_r;
  assign irq = |maskedIrq;

  assign dmaReq.rxReq = dmaCtl_r[DMA_RX_BIT] && rxDmaNeed;
  assign dmaReq.txReq = dmaCtl_r[DMA_TX_BIT] && txDmaNeed;

  assign rxFrameCount = rx_frame_count_r;
  assign txfifoRxFrameCount = txFrm_r;
  assign fifoSwapSelect = testCtl_r[SWAP_BIT];

  assign dummyMask = (frameBits == 5'h1f) ? 32'hffffffff : ((32'h00000002 << frameBits) - 32'h1);
  always_ff @(posedge clk) begin
    if (srst) begin
      txDummyData <= WORD_RESET;
    end else begin
      txDummyData <= rxOnly ? (dummy_r & dummyMask) : WORD_RESET;
    end
  end

  logic tdWr;
  logic tdRd;
  assign tdWr = wrPend_r && addr_r == ADDR_TDATA;
  assign tdRd = addrTake && !hwrite && haddr[7:0] == ADDR_TDATA;
  assign txPush = tdWr && !testCtl_r[SWAP_BIT];
  assign rxPush = tdWr && testCtl_r[SWAP_BIT];
  assign rxPop = tdRd && !testCtl_r[SWAP_BIT];
  assign txPop = tdRd && testCtl_r[SWAP_BIT];
  assign testPushData = hwdata[DW-1:0];

  a_ovr_sets: assert property (@(posedge clk) disable iff (srst)
    (rxWrite && rxFull) |=> rawIrq_r[IRQ_ROR]) else $error("overrun not set");
  a_mis_and: assert property (@(posedge clk) disable iff (srst)
    maskedIrq == (rawIrq_r & mask_r)) else $error("masked status wrong");
  a_ror_clr: assert property (@(posedge clk) disable iff (srst)
    (wrPend_r && addr_r == ADDR_ICLR && hwdata[0] && !setIrq[0]) |=> !rawIrq_r[0])
    else $error("overrun not cleared");
  a_rt_clr: assert property (@(posedge clk) disable iff (srst)
    (wrPend_r && addr_r == ADDR_ICLR && hwdata[1] && !setIrq[1]) |=> !rawIrq_r[1])
    else $error("timeout not cleared");
  a_tur_clr: assert property (@(posedge clk) disable iff (srst)
    (wrPend_r && addr_r == ADDR_ICLR && hwdata[2] && !setIrq[4]) |=> !rawIrq_r[4])
    else $error("underrun not cleared");
  a_clr_zero: assert property (@(posedge clk) disable iff (srst)
    (wrPend_r && addr_r == ADDR_ICLR && !hwdata[0] && rawIrq_r[0]) |=> rawIrq_r[0])
    else $error("zero cleared flag");
  a_rxdma_gate: assert property (@(posedge clk) disable iff (srst)
    dmaReq.rxReq |-> (dmaCtl_r[0] && rxDmaNeed)) else $error("rx dma ungated");
  a_txdma_gate: assert property (@(posedge clk) disable iff (srst)
    dmaReq.txReq |-> (dmaCtl_r[2] && txDmaNeed)) else $error("tx dma ungated");
  a_frm_write: assert property (@(posedge clk) disable iff (srst)
    (wrPend_r && addr_r == ADDR_RX_FRAME_COUNT) |=> rx_frame_count_r == $past(hwdata[15:0]))
    else $error("frame count not written");
  a_txfrm_write: assert property (@(posedge clk) disable iff (srst)
    (wrPend_r && addr_r == ADDR_TXFRM) |=> txFrm_r == $past(hwdata[15:0]))
    else $error("tx frame count not written");
  a_swap_pop: assert property (@(posedge clk) disable iff (srst)
    tdRd |-> (txPop != rxPop) && (txPop == testCtl_r[1])) else $error("swap pop wrong");
  a_norm_push: assert property (@(posedge clk) disable iff (srst)
    tdWr |-> (txPush == !testCtl_r[1]) && (rxPush == testCtl_r[1]))
    else $error("push route wrong");
  a_dummy_out: assert property (@(posedge clk) disable iff (srst)
    !rxOnly |=> txDummyData == 32'h00000000) else $error("dummy leaked");

  // The interrupt line must agree with the masked status at every edge.
  // Software polls the masked status instead of the line on some systems.
  // So the two are checked against each other rather than each against a model.
  a_irq_level: assert property (@(posedge clk) disable iff (srst)
    irq == (|(rawIrq_r & mask_r)))
    else $error("irq disagrees with masked status");
  a_mask_block: assert property (@(posedge clk) disable iff (srst)
    !mask_r[IRQ_ROR] |-> !maskedIrq[IRQ_ROR])
    else $error("masked overrun leaked");
  a_mask_pass: assert property (@(posedge clk) disable iff (srst)
    (mask_r[IRQ_TUR] && rawIrq_r[IRQ_TUR]) |-> maskedIrq[IRQ_TUR])
    else $error("enabled underrun hidden");

  // Level flags clear on a read of the masked status unless a new event lands.
  // An event in the clearing cycle must survive, or a pulse would be lost.
  a_rx_rdclr: assert property (@(posedge clk) disable iff (srst)
    (rdPend_r && addr_r == ADDR_MIS && !setIrq[IRQ_RX]) |=> !rawIrq_r[IRQ_RX])
    else $error("rx level not cleared by read");
  a_te_rdclr: assert property (@(posedge clk) disable iff (srst)
    (rdPend_r && addr_r == ADDR_MIS && !setIrq[IRQ_TE]) |=> !rawIrq_r[IRQ_TE])
    else $error("tx empty not cleared by read");
  a_set_wins: assert property (@(posedge clk) disable iff (srst)
    setIrq[IRQ_ROR] |=> rawIrq_r[IRQ_ROR])
    else $error("overrun event lost");
  a_push_ovr: assert property (@(posedge clk) disable iff (srst)
    (rxPush && rxFull) |=> rawIrq_r[IRQ_ROR])
    else $error("test push overrun not seen");

  // Clear bits written as zero must not disturb the other pending flags.
  a_rt_keep: assert property (@(posedge clk) disable iff (srst)
    (wrPend_r && addr_r == ADDR_ICLR && !hwdata[1] && rawIrq_r[IRQ_RT]) |=> rawIrq_r[IRQ_RT])
    else $error("timeout cleared by zero");
  a_tur_keep: assert property (@(posedge clk) disable iff (srst)
    (wrPend_r && addr_r == ADDR_ICLR && !hwdata[2] && rawIrq_r[IRQ_TUR]) |=> rawIrq_r[IRQ_TUR])
    else $error("underrun cleared by zero");

  // The request lines follow the enables both ways, so a stuck request shows up.
  a_rxdma_on: assert property (@(posedge clk) disable iff (srst)
    (dmaCtl_r[DMA_RX_BIT] && rxDmaNeed) |-> dmaReq.rxReq)
    else $error("rx dma request missing");
  a_rxdma_off: assert property (@(posedge clk) disable iff (srst)
    !dmaCtl_r[DMA_RX_BIT] |-> !dmaReq.rxReq)
    else $error("rx dma request while disabled");
  a_txdma_on: assert property (@(posedge clk) disable iff (srst)
    (dmaCtl_r[DMA_TX_BIT] && txDmaNeed) |-> dmaReq.txReq)
    else $error("tx dma request missing");
  a_txdma_off: assert property (@(posedge clk) disable iff (srst)
    !dmaCtl_r[DMA_TX_BIT] |-> !dmaReq.txReq)
    else $error("tx dma request while disabled");

  // The frame counts only move on a write to their own offset.
  a_frm_hold: assert property (@(posedge clk) disable iff (srst)
    !(wrPend_r && addr_r == ADDR_RX_FRAME_COUNT) |=> rx_frame_count_r == $past(rx_frame_count_r))
    else $error("frame count drifted");
  a_txfrm_hold: assert property (@(posedge clk) disable iff (srst)
    !(wrPend_r && addr_r == ADDR_TXFRM) |=> txFrm_r == $past(txFrm_r))
    else $error("tx frame count drifted");
  a_dummy_val: assert property (@(posedge clk) disable iff (srst)
    rxOnly |=> txDummyData == $past(dummy_r & dummyMask))
    else $error("dummy not right-justified");

  // One test data access touches exactly one FIFO, never both.
  a_push_excl: assert property (@(posedge clk) disable iff (srst)
    !(txPush && rxPush))
    else $error("both fifos pushed");
  a_pop_excl: assert property (@(posedge clk) disable iff (srst)
    !(txPop && rxPop))
    else $error("both fifos popped");
  a_norm_rdata: assert property (@(posedge clk) disable iff (srst)
    (tdRd && !testCtl_r[SWAP_BIT]) |=> hrdata == 32'($past(rxHead)))
    else $error("normal test read wrong source");
  a_swap_rdata: assert property (@(posedge clk) disable iff (srst)
    (tdRd && testCtl_r[SWAP_BIT]) |=> hrdata == 32'($past(txHead)))
    else $error("swapped test read wrong source");
  a_swap_out: assert property (@(posedge clk) disable iff (srst)
    fifoSwapSelect == testCtl_r[SWAP_BIT])
    else $error("swap select output wrong");
endmodule
`default_nettype wire

// file: verification/sidc_fifo_model.sv
`timescale 1ns/1ps
`default_nettype none
module sidc_fifo_model (
  input wire logic clk,
  input wire logic txPush,
  input wire logic rxPush,
  input wire logic [31:0] pushData,
  input wire logic txPop,
  input wire logic rxPop,
  output logic [31:0] txHead,
  output logic [31:0] rxHead,
  output logic [31:0] txLevel
);
  logic [31:0] txq[$];
  logic [31:0] rxq[$];
  logic [31:0] pat = 32'h0;
  // An empty queue shows a moving pattern, so a pop from it never reads stale data.
  always @(posedge clk) begin
    if (txPush) txq.push_back(pushData);
    if (rxPush) rxq.push_back(pushData);
    if (txPop && txq.size() != 0) void'(txq.pop_front());
    if (rxPop && rxq.size() != 0) void'(rxq.pop_front());
    pat <= pat + 32'h1;
    txHead <= (txq.size() != 0) ? txq[0] : ~pat;
    rxHead <= (rxq.size() != 0) ? rxq[0] : ~pat;
    txLevel <= 32'(txq.size());
  end
endmodule
`default_nettype wire

// file: verification/tb_spi_irq_dma_fifo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spi_irq_dma_fifo_ctrl;
  import sidc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdPend = 1'b0;
  logic rxFull = 1'b0, rxWrite = 1'b0, rxDmaNeed = 1'b0, txDmaNeed = 1'b0, rxOnly = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h6948;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] frameBits = 5'h0;
  sidc_events_t events = 5'h0;
  sidc_dma_t dmaReq;
  logic hreadyout, hresp, irq, fifoSwapSelect, txPush, rxPush, txPop, rxPop;
  logic [15:0] rxFrameCount, txfifoRxFrameCount;
  logic [31:0] hrdata, txDummyData, testPushData, txHead, rxHead, txLevel;
  int err_count = 0, num_checks = 0;
  logic [31:0] expQ[$];
  logic [7:0] regs[6] = '{ADDR_MIS, ADDR_DMAC, ADDR_RX_FRAME_COUNT, ADDR_DUMMY, ADDR_TXFRM, ADDR_TCTL};
  logic [31:0] clrBit[3] = '{32'h1, 32'h2, 32'h10};
  always #5 clk = ~clk;
  sidc_ctrl #(.DW(32)) sidc_ctrl_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .events(events), .rxFull(rxFull),
    .rxWrite(rxWrite), .rxDmaNeed(rxDmaNeed), .txDmaNeed(txDmaNeed), .dmaReq(dmaReq),
    .rxOnly(rxOnly), .frameBits(frameBits), .txDummyData(txDummyData),
    .rxFrameCount(rxFrameCount), .txfifoRxFrameCount(txfifoRxFrameCount),
    .fifoSwapSelect(fifoSwapSelect), .txPush(txPush), .rxPush(rxPush),
    .testPushData(testPushData), .txPop(txPop), .rxPop(rxPop), .txHead(txHead),
    .rxHead(rxHead), .irq(irq));
  sidc_fifo_model sidc_fifo_model_inst (.clk(clk), .txPush(txPush), .rxPush(rxPush),
    .pushData(testPushData), .txPop(txPop), .rxPop(rxPop), .txHead(txHead), .rxHead(rxHead),
    .txLevel(txLevel));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdPend <= !w;
    edge_ready();
    rdPend <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic fire(input logic [4:0] ev, input logic ovr);
    events <= ev;
    rxFull <= ovr;
    rxWrite <= ovr;
    @(posedge clk);
    events <= 5'h0;
    rxFull <= 1'b0;
    rxWrite <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Read data stands in the data phase, so it is taken at the edge that closes it.
  always @(posedge clk) if (rdPend) cmp(hrdata, expQ.pop_front());
  initial begin
    logic [31:0] v;
    logic [31:0] e;
    logic [32:0] m;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (regs[i]) rd(regs[i], 32'h0);
    v = xs();
    wr(ADDR_RX_FRAME_COUNT, {16'h0, v[15:0]});
    rd(ADDR_RX_FRAME_COUNT, {16'h0, v[15:0]});
    wr(ADDR_TXFRM, {16'h0, v[31:16]});
    rd(ADDR_TXFRM, {16'h0, v[31:16]});
    cmp({16'h0, rxFrameCount}, {16'h0, v[15:0]});
    cmp({16'h0, txfifoRxFrameCount}, {16'h0, v[31:16]});
    rxDmaNeed <= 1'b1;
    txDmaNeed <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DMAC, {29'h0, i[1], 1'b0, i[0]});
      #1 cmp({30'h0, dmaReq}, {30'h0, i[1], i[0]});
    end
    v = xs();
    m = (33'h1 << (v[4:0] + 1)) - 33'h1;
    wr(ADDR_DUMMY, v);
    rd(ADDR_DUMMY, v);
    frameBits <= v[4:0];
    rxOnly <= 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp(txDummyData, v & m[31:0]);
    rxOnly <= 1'b0;
    repeat (3) @(posedge clk);
    #1 cmp(txDummyData, 32'h0);
    wr(ADDR_IMASK, 32'h3f);
    fire(5'h1f, 1'b1);
    cmp({31'h0, irq}, 32'h1);
    rd(ADDR_MIS, 32'h3f);
    wr(ADDR_ICLR, 32'h0);
    e = 32'h13;
    rd(ADDR_MIS, e);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_ICLR, 32'h1 << k);
      e = e & ~clrBit[k];
      rd(ADDR_MIS, e);
    end
    #1 cmp({31'h0, irq}, 32'h0);
    wr(ADDR_IMASK, 32'h0);
    fire(5'h0, 1'b1);
    cmp({31'h0, irq}, 32'h0);
    rd(ADDR_MIS, 32'h0);
    rd(ADDR_RAW, 32'h1);
    wr(ADDR_ICLR, 32'h1);
    v = xs();
    wr(ADDR_TDATA, v);
    wr(ADDR_TDATA, ~v);
    wr(ADDR_TCTL, 32'h2);
    rd(ADDR_TCTL, 32'h2);
    cmp({31'h0, fifoSwapSelect}, 32'h1);
    rd(ADDR_TDATA, v);
    rd(ADDR_TDATA, ~v);
    cmp(txLevel, 32'h0);
    wr(ADDR_TDATA, v ^ 32'h5a5a);
    wr(ADDR_TCTL, 32'h0);
    rd(ADDR_TDATA, v ^ 32'h5a5a);
    repeat (2) @(posedge clk);
    report_and_stop();
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
endmodule
`default_nettype wire
